/* hdl/ufc_defs.vh */
`ifndef UFC_DEFS_VH
`define UFC_DEFS_VH
// ***************************************************************
// register map, index of each register on the plain port
// ***************************************************************
`define UFC_ADDR_W 3
`define UFC_REG_DATA 3'h0
`define UFC_REG_IEN 3'h1
`define UFC_REG_IDENT 3'h2
`define UFC_REG_LINE_CTL 3'h3
`define UFC_REG_LSTATE 3'h5
// ***************************************************************
// field positions
// ***************************************************************
`define UFC_FS_ON 0
`define UFC_FS_RXCLR 1
`define UFC_FS_TXCLR 2
`define UFC_FS_DMA 3
`define UFC_FS_TRIG_LO 6
`define UFC_FS_TRIG_HI 7
`define UFC_IE_RX 0
`define UFC_IE_TX 1
`define UFC_IE_LS 2
`define UFC_IE_MS 3
`define UFC_LC_STB 2
// ***************************************************************
// identification codes and levels
// ***************************************************************
`define UFC_ID_NONE 4'h1
`define UFC_ID_LS 4'h6
`define UFC_ID_RDA 4'h4
`define UFC_ID_TMO 4'hc
`define UFC_ID_TX_HOLDING_EMPTY 4'h2
`define UFC_ID_MS 4'h0
`define UFC_TRIG_1 5'h01
`define UFC_TRIG_4 5'h04
`define UFC_TRIG_8 5'h08
`define UFC_TRIG_14 5'h0e
`define UFC_TMO_CHARS 4'h4
`define UFC_RCLK_PER_BIT 8'h10
`define UFC_BITS_PER_CHAR 8'h0a
`endif

/* hdl/ufc_core.v */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_defs.vh"
module ufc_core #(
  parameter DEPTH = 16,
  parameter CW = 5
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire rclk_tick_i,
  input wire rx_push_i,
  input wire [7:0] rx_char_i,
  input wire [3:0] rx_err_i,
  input wire tx_pop_i,
  input wire tx_shifter_empty_i,
  input wire tx_last_stop_i,
  input wire modem_change_i,
  output wire [7:0] tx_char_o,
  output wire tx_avail_o,
  output wire irq_output_o,
  output wire rx_dma_request_n_o,
  output wire tx_dma_request_n_o
);
  // ***************************************************************
  // storage
  // ***************************************************************
  reg [7:0] rx_mem [0:DEPTH-1];
  reg [3:0] rx_emem [0:DEPTH-1];
  reg [7:0] tx_mem [0:DEPTH-1];
  reg [CW-1:0] rx_cnt_q, tx_cnt_q;
  reg [CW-2:0] rx_rp_q, rx_wp_q, tx_rp_q, tx_wp_q;
  reg fifo_on_bit_q, dma_signal_mode_bit_q;
  reg [1:0] trig_q;
  reg [3:0] ien_q;
  reg stb_q;
  reg [3:0] err_sticky_q;
  reg tx_holding_empty_pend_q, tmo_pend_q, two_seen_q, first_q, tx_holding_empty_wait_q, tx_emp_q;
  reg [7:0] tmo_tick_q, tx_holding_empty_tick_q;
  reg [3:0] tmo_chars_q;
  reg [7:0] line_ctl_q;
  reg [CW-1:0] trig_lvl;
  reg [3:0] ident;
  reg [7:0] rd_mux;
  reg err_in_fifo;
  integer i;

  wire w_ctl = wr_i && addr_i == `UFC_REG_IDENT;
  wire w_ctl_ok = w_ctl && wdata_i[`UFC_FS_ON];
  wire toggle = w_ctl && (wdata_i[`UFC_FS_ON] != fifo_on_bit_q);
  wire rx_clr = toggle || (w_ctl_ok && wdata_i[`UFC_FS_RXCLR]);
  wire tx_clr = toggle || (w_ctl_ok && wdata_i[`UFC_FS_TXCLR]);
  wire host_rd = rd_i && addr_i == `UFC_REG_DATA && rx_cnt_q != {CW{1'b0}};
  wire host_wr = wr_i && addr_i == `UFC_REG_DATA && tx_cnt_q != DEPTH[CW-1:0];
  wire rx_in = rx_push_i && rx_cnt_q != DEPTH[CW-1:0];
  wire tx_out = tx_pop_i && tx_cnt_q != {CW{1'b0}};
  wire id_rd = rd_i && addr_i == `UFC_REG_IDENT;
  wire ls_rd = rd_i && addr_i == `UFC_REG_LSTATE;

  // trigger level decode
  always @* begin
    case (trig_q)
      2'b00: trig_lvl = `UFC_TRIG_1;
      2'b01: trig_lvl = `UFC_TRIG_4;
      2'b10: trig_lvl = `UFC_TRIG_8;
      default: trig_lvl = `UFC_TRIG_14;
    endcase
  end

  // ***************************************************************
  // interrupt sources, gated by enables (polled mode = enable low)
  // ***************************************************************
  wire src_ls = ien_q[`UFC_IE_LS] && err_sticky_q != 4'h0;
  wire src_rda = ien_q[`UFC_IE_RX] && (fifo_on_bit_q ? rx_cnt_q >= trig_lvl
                 : rx_cnt_q != {CW{1'b0}});
  wire src_tmo = ien_q[`UFC_IE_RX] && fifo_on_bit_q && tmo_pend_q;
  wire src_tx_holding_empty = ien_q[`UFC_IE_TX] && tx_holding_empty_pend_q;
  wire src_ms = ien_q[`UFC_IE_MS] && modem_change_i;

  // priority encoder
  always @* begin
    if (src_ls)
      ident = `UFC_ID_LS;
    else if (src_rda)
      ident = `UFC_ID_RDA;
    else if (src_tmo)
      ident = `UFC_ID_TMO;
    else if (src_tx_holding_empty)
      ident = `UFC_ID_TX_HOLDING_EMPTY;
    else if (src_ms)
      ident = `UFC_ID_MS;
    else
      ident = `UFC_ID_NONE;
  end
  assign irq_output_o = ~ident[0];

  // read mux, registered one cycle later
  always @* begin
    case (addr_i)
      `UFC_REG_DATA: rd_mux = rx_mem[rx_rp_q];
      `UFC_REG_IEN: rd_mux = {4'h0, ien_q};
      `UFC_REG_IDENT: rd_mux = {{2{fifo_on_bit_q}}, 2'b00, ident};
      `UFC_REG_LINE_CTL: rd_mux = line_ctl_q;
      `UFC_REG_LSTATE: rd_mux = {err_in_fifo, tx_emp_q && tx_shifter_empty_i,
                                 tx_cnt_q == {CW{1'b0}}, err_sticky_q, rx_cnt_q != {CW{1'b0}}};
      default: rd_mux = 8'h00;
    endcase
  end

  // any errored byte still in receive FIFO
  always @* begin
    err_in_fifo = 1'b0;
    for (i = 0; i < DEPTH; i = i + 1)
      if (i < rx_cnt_q && rx_emem[(rx_rp_q + i) % DEPTH] != 4'h0)
        err_in_fifo = 1'b1;
  end

  // ***************************************************************
  // registers and fifos
  // ***************************************************************
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      fifo_on_bit_q <= 1'b0;
      dma_signal_mode_bit_q <= 1'b0;
      trig_q <= 2'b00;
      ien_q <= 4'h0;
      line_ctl_q <= 8'h00;
      stb_q <= 1'b0;
      rx_cnt_q <= {CW{1'b0}};
      tx_cnt_q <= {CW{1'b0}};
      rx_rp_q <= {(CW-1){1'b0}};
      rx_wp_q <= {(CW-1){1'b0}};
      tx_rp_q <= {(CW-1){1'b0}};
      tx_wp_q <= {(CW-1){1'b0}};
      err_sticky_q <= 4'h0;
    end else begin
      if (rd_i)
        rdata_o <= rd_mux;
      if (w_ctl) begin
        fifo_on_bit_q <= wdata_i[`UFC_FS_ON];
        if (w_ctl_ok) begin
          dma_signal_mode_bit_q <= wdata_i[`UFC_FS_DMA];
          trig_q <= wdata_i[`UFC_FS_TRIG_HI:`UFC_FS_TRIG_LO];
        end
      end
      if (wr_i && addr_i == `UFC_REG_IEN)
        ien_q <= wdata_i[3:0];
      if (wr_i && addr_i == `UFC_REG_LINE_CTL) begin
        line_ctl_q <= wdata_i;
        stb_q <= wdata_i[`UFC_LC_STB];
      end
      // error flags: new error wins over read clear
      err_sticky_q <= (ls_rd ? 4'h0 : err_sticky_q) | (rx_in ? rx_err_i : 4'h0);
      // receive fifo
      if (rx_clr) begin
        rx_cnt_q <= {CW{1'b0}};
        rx_rp_q <= {(CW-1){1'b0}};
        rx_wp_q <= {(CW-1){1'b0}};
      end else begin
        if (rx_in)
          rx_wp_q <= rx_wp_q + 1'b1;
        if (host_rd)
          rx_rp_q <= rx_rp_q + 1'b1;
        rx_cnt_q <= rx_cnt_q + {{(CW-1){1'b0}}, rx_in} - {{(CW-1){1'b0}}, host_rd};
      end
      // transmit fifo
      if (tx_clr) begin
        tx_cnt_q <= {CW{1'b0}};
        tx_rp_q <= {(CW-1){1'b0}};
        tx_wp_q <= {(CW-1){1'b0}};
      end else begin
        if (host_wr)
          tx_wp_q <= tx_wp_q + 1'b1;
        if (tx_out)
          tx_rp_q <= tx_rp_q + 1'b1;
        tx_cnt_q <= tx_cnt_q + {{(CW-1){1'b0}}, host_wr} - {{(CW-1){1'b0}}, tx_out};
      end
    end
  end

  // memory writes, no reset on data
  always @(posedge core_clk_i) begin
    if (rx_in && !rx_clr) begin
      rx_mem[rx_wp_q] <= rx_char_i;  // shifter delivers bit 0 first
      rx_emem[rx_wp_q] <= rx_err_i;
    end
    if (host_wr && !tx_clr)
      tx_mem[tx_wp_q] <= wdata_i;
  end
  assign tx_char_o = tx_mem[tx_rp_q];   // shifter sends bit 0 first
  assign tx_avail_o = tx_cnt_q != {CW{1'b0}};

  // ***************************************************************
  // character time-out, counted in receiver clock ticks
  // ***************************************************************
  wire tmo_restart = rx_in || host_rd || rx_clr;
  wire [7:0] char_ticks = `UFC_RCLK_PER_BIT * (`UFC_BITS_PER_CHAR + {7'h00, stb_q});
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmo_tick_q <= 8'h00;
      tmo_chars_q <= 4'h0;
      tmo_pend_q <= 1'b0;
    end else if (tmo_restart || rx_cnt_q == {CW{1'b0}}) begin
      tmo_tick_q <= 8'h00;
      tmo_chars_q <= 4'h0;
      tmo_pend_q <= 1'b0;
    end else if (rclk_tick_i && !tmo_pend_q) begin
      if (tmo_tick_q == char_ticks - 8'h01) begin
        tmo_tick_q <= 8'h00;
        tmo_chars_q <= tmo_chars_q + 4'h1;
        if (tmo_chars_q == `UFC_TMO_CHARS - 4'h1)
          tmo_pend_q <= 1'b1;
      end else
        tmo_tick_q <= tmo_tick_q + 8'h01;
    end
  end

  // ***************************************************************
  // holding-empty interrupt with optional one-char delay
  // ***************************************************************
  wire tx_now_empty = tx_cnt_q == {CW{1'b0}};
  wire tx_going_empty = tx_out && tx_cnt_q == {{(CW-1){1'b0}}, 1'b1};
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_holding_empty_pend_q <= 1'b0;
      two_seen_q <= 1'b0;
      first_q <= 1'b1;
      tx_holding_empty_wait_q <= 1'b0;
      tx_holding_empty_tick_q <= 8'h00;
      tx_emp_q <= 1'b1;
    end else begin
      tx_emp_q <= tx_now_empty;
      if (tx_cnt_q >= {{(CW-2){1'b0}}, 2'b10})
        two_seen_q <= 1'b1;
      if (toggle) begin
        // the immediate interrupt is given here, so later ones may be delayed
        first_q <= 1'b0;
        tx_holding_empty_wait_q <= 1'b0;
        tx_holding_empty_pend_q <= 1'b1;                             // immediate
      end else if (host_wr) begin
        tx_holding_empty_pend_q <= 1'b0;
        tx_holding_empty_wait_q <= 1'b0;
      end else if (tx_going_empty || tx_clr) begin
        two_seen_q <= 1'b0;
        if (two_seen_q || first_q || !fifo_on_bit_q) begin
          tx_holding_empty_pend_q <= 1'b1;
          first_q <= 1'b0;
        end else begin
          tx_holding_empty_wait_q <= 1'b1;
          tx_holding_empty_tick_q <= 8'h00;
        end
      end else if (tx_holding_empty_wait_q && rclk_tick_i) begin
        // one char minus last stop bit
        if (tx_last_stop_i || tx_holding_empty_tick_q == char_ticks - `UFC_RCLK_PER_BIT) begin
          tx_holding_empty_wait_q <= 1'b0;
          tx_holding_empty_pend_q <= 1'b1;
        end else
          tx_holding_empty_tick_q <= tx_holding_empty_tick_q + 8'h01;
      end else if (id_rd && ident == `UFC_ID_TX_HOLDING_EMPTY)
        tx_holding_empty_pend_q <= 1'b0;
    end
  end

  // ***************************************************************
  // dma request signalling, active low
  // ***************************************************************
  wire mode1 = fifo_on_bit_q && dma_signal_mode_bit_q;
  assign rx_dma_request_n_o = mode1 ? !(rx_cnt_q >= trig_lvl || tmo_pend_q)
                                    : rx_cnt_q == {CW{1'b0}};
  assign tx_dma_request_n_o = mode1 ? tx_cnt_q == DEPTH[CW-1:0]
                                    : !tx_now_empty;
endmodule // ufc_core
`default_nettype wire

/* tb/ufc_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ******
// port checker
// ******
module ufc_core_properties (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic tx_avail_o,
  input wire logic irq_output_o
);
  logic [3:0] ien_q;
  logic on_q;
  // shadow of enables and fifo-on, kept from the write strobes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ien_q <= 4'h0;
      on_q <= 1'b0;
    end else if (wr_i && addr_i == 3'h1) begin
      ien_q <= wdata_i[3:0];
    end else if (wr_i && addr_i == 3'h2) begin
      on_q <= wdata_i[0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ien_rd; rd_i && addr_i == 3'h1 |=> rdata_o == {4'h0, $past(ien_q)}; endproperty
  a_ien_rd: assert property (p_ien_rd) else $error("enable readback wrong");
  property p_id_hi; rd_i && addr_i == 3'h2 |=> rdata_o[7:4] == {{2{$past(on_q)}}, 2'b00}; endproperty
  a_id_hi: assert property (p_id_hi) else $error("ident upper bits wrong");
  property p_id_tmo; rd_i && addr_i == 3'h2 && !on_q |=> !rdata_o[3]; endproperty
  a_id_tmo: assert property (p_id_tmo) else $error("timeout bit outside fifo mode");
  property p_irq_off; ien_q == 4'h0 |-> !irq_output_o; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with all enables clear");
  property p_txclr; wr_i && addr_i == 3'h2 && wdata_i[0] && wdata_i[2] |=> !tx_avail_o; endproperty
  a_txclr: assert property (p_txclr) else $error("tx fifo not cleared");
  property p_toggle; wr_i && addr_i == 3'h2 && wdata_i[0] != on_q |=> !tx_avail_o; endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flush");
  property p_hold; !rd_i |=> $stable(rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; rd_i && (addr_i == 3'h4 || addr_i > 3'h5) |=> rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // ufc_core_properties
bind ufc_core ufc_core_properties i_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_avail_o(tx_avail_o),
  .irq_output_o(irq_output_o));
`default_nettype wire

/* tb/ufc_line_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ******
// serial side: shifters and receiver clock
// ******
module ufc_line_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic push_req_i,
  input wire logic [7:0] push_char_i,
  input wire logic [3:0] push_err_i,
  input wire logic tx_avail_i,
  input wire logic [7:0] tx_char_i,
  output logic rclk_tick_o,
  output logic rx_push_o,
  output logic [7:0] rx_char_o,
  output logic [3:0] rx_err_o,
  output logic tx_pop_o,
  output logic tx_empty_o,
  output logic tx_last_stop_o,
  output logic [7:0] last_tx_o
);
  logic tick_q;
  logic [7:0] ticks_q;
  // tick every other cycle keeps char times short in the run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 1'b0;
      ticks_q <= 8'h00;
      rx_push_o <= 1'b0;
      rx_char_o <= 8'h00;
      rx_err_o <= 4'h0;
      tx_pop_o <= 1'b0;
      last_tx_o <= 8'h00;
    end else begin
      tick_q <= !tick_q;
      rx_push_o <= push_req_i;
      // idle bus inverts its last value each cycle, so a stale copy returns every other cycle
      rx_char_o <= push_req_i ? push_char_i : ~rx_char_o;
      rx_err_o <= push_req_i ? push_err_i : 4'h0;
      tx_pop_o <= 1'b0;
      if (ticks_q != 8'h00) begin
        if (tick_q) ticks_q <= ticks_q - 8'h01;
      end else if (tx_avail_i && !tx_pop_o) begin
        tx_pop_o <= 1'b1;
        last_tx_o <= tx_char_i;
        ticks_q <= 8'ha0;
      end
    end
  end
  assign rclk_tick_o = tick_q;
  assign tx_empty_o = (ticks_q == 8'h00);
  assign tx_last_stop_o = tick_q && (ticks_q == 8'h10);
endmodule // ufc_line_model
`default_nettype wire

/* tb/tb_ufc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ufc_core;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic modem = 1'b0;
  logic preq = 1'b0;
  logic [7:0] pch = 8'h00;
  logic [3:0] perr = 4'h0;
  wire [7:0] rdata, rxc, txc, last_tx;
  wire [3:0] rxe;
  wire tick, rxp, txp, txe, tls, txa, irq, rxdn, txdn;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] v;
  int lv [4] = '{1, 4, 8, 14};
  always #25 clk = ~clk;
  ufc_core i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .rclk_tick_i(tick), .rx_push_i(rxp), .rx_char_i(rxc), .rx_err_i(rxe), .tx_pop_i(txp),
    .tx_shifter_empty_i(txe), .tx_last_stop_i(tls), .modem_change_i(modem), .tx_char_o(txc),
    .tx_avail_o(txa), .irq_output_o(irq), .rx_dma_request_n_o(rxdn), .tx_dma_request_n_o(txdn));
  ufc_line_model i_line (.clk_i(clk), .rst_n_i(rst_n), .push_req_i(preq), .push_char_i(pch),
    .push_err_i(perr), .tx_avail_i(txa), .tx_char_i(txc), .rclk_tick_o(tick), .rx_push_o(rxp),
    .rx_char_o(rxc), .rx_err_o(rxe), .tx_pop_o(txp), .tx_empty_o(txe), .tx_last_stop_o(tls),
    .last_tx_o(last_tx));
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(v, e);
  endtask
  task automatic push(input logic [7:0] c, input logic [3:0] e);
    @(posedge clk);
    preq <= 1'b1;
    pch <= c;
    perr <= e;
    @(posedge clk);
    preq <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // bounded wait for the interrupt level; zero means look now
  task automatic wait_irq(input logic e, input int n);
    for (int i = 0; i < n && irq !== e; i++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, irq}, {7'h00, e});
    if (irq !== e) end_sim();
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk(3'h2, 8'h01);
    rchk(3'h4, 8'h00);
    wr8(3'h1, 8'hff);
    rchk(3'h1, 8'h0f);
    wr8(3'h1, 8'h00);
    wr8(3'h2, 8'h01);
    rchk(3'h2, 8'hc1);
    wr8(3'h2, 8'hc8);
    rchk(3'h2, 8'h01);
    // every trigger code, fill up to the level and one below it
    for (int t = 0; t < 4; t++) begin
      wr8(3'h2, {t[1:0], 6'h07});
      wr8(3'h1, 8'h01);
      for (int k = 0; k < lv[t]; k++) begin
        wait_irq(1'b0, 0);
        push(8'h30 + k[7:0], 4'h0);
      end
      wait_irq(1'b1, 0);
      rchk(3'h2, 8'hc4);
      rchk(3'h0, 8'h30);
      wait_irq(1'b0, 0);
    end
    wr8(3'h2, 8'hc3);
    push(8'h5a, 4'h0);
    push(8'h5b, 4'h0);
    repeat (1200) @(posedge clk);
    wait_irq(1'b0, 0);
    wait_irq(1'b1, 400);
    rchk(3'h2, 8'hcc);
    rchk(3'h0, 8'h5a);
    rchk(3'h2, 8'hc1);
    wr8(3'h1, 8'h00);
    repeat (1500) @(posedge clk);
    rchk(3'h2, 8'hc1);
    rchk(3'h5, 8'h61);
    wr8(3'h2, 8'h03);
    rchk(3'h5, 8'h60);
    #1;
    chk({7'h00, rxdn}, 8'h01);
    chk({7'h00, txdn}, 8'h00);
    wr8(3'h1, 8'h05);
    push(8'h11, 4'h2);
    rchk(3'h2, 8'hc6);
    rchk(3'h5, 8'he5);
    rchk(3'h2, 8'hc4);
    wr8(3'h1, 8'h00);
    wr8(3'h2, 8'h00);
    wr8(3'h2, 8'h01);
    wr8(3'h1, 8'h02);
    rchk(3'h2, 8'hc2);
    rchk(3'h2, 8'hc1);
    wr8(3'h0, 8'ha5);
    repeat (100) @(posedge clk);
    wait_irq(1'b0, 0);
    wait_irq(1'b1, 2000);
    chk(last_tx, 8'ha5);
    rchk(3'h2, 8'hc2);
    @(posedge clk);
    modem <= 1'b1;
    wr8(3'h1, 8'h08);
    rchk(3'h2, 8'hc0);
    // mode 0 asks for service on one byte, mode 1 waits for the trigger
    wr8(3'h2, 8'hc1);
    push(8'h22, 4'h0);
    chk({7'h00, rxdn}, 8'h00);
    wr8(3'h2, 8'hc9);
    #1;
    chk({7'h00, rxdn}, 8'h01);
    chk({7'h00, txdn}, 8'h00);
    end_sim();
  end
endmodule // tb_ufc_core
`default_nettype wire
